// File: cmpctl_consts.vh
// constants for the comparator control block: register indices,
// field positions, reset values and mode encodings.
// assumes nothing; definitions only.
`ifndef CMPCTL_CONSTS_VH
`define CMPCTL_CONSTS_VH

// register indices; byte address is four times the index
`define CMPCTL_IDX_MAIN      3'd0
`define CMPCTL_IDX_WINDOW    3'd1
`define CMPCTL_IDX_INSEL     3'd2
`define CMPCTL_IDX_THRESH    3'd5
`define CMPCTL_IDX_IRQCTL    3'd6
`define CMPCTL_IDX_STATUS    3'd7

// main control fields
`define CMPCTL_MAIN_EN       0
`define CMPCTL_MAIN_HYS_LO   1
`define CMPCTL_MAIN_PWR_LO   3
`define CMPCTL_MAIN_PINEN    6
`define CMPCTL_MAIN_STDBY    7
`define CMPCTL_MAIN_MASK     8'hdf

// input select fields
`define CMPCTL_INSEL_NEG_LO  0
`define CMPCTL_INSEL_POS_LO  3
`define CMPCTL_INSEL_INIT    6
`define CMPCTL_INSEL_INV     7

// irq control and status fields
`define CMPCTL_IRQ_EN        0
`define CMPCTL_IRQ_COND_LO   4
`define CMPCTL_IRQ_MASK      8'h31
`define CMPCTL_WIN_MASK      8'h03
`define CMPCTL_ST_FLAG       0
`define CMPCTL_ST_MATCH      4
`define CMPCTL_ST_POS_LO     6

// reset values
`define CMPCTL_RST_ZERO      8'h00
`define CMPCTL_RST_THRESH    8'hff

// window partner, irq condition and window position codes
`define CMPCTL_WIN_OFF       2'h0
`define CMPCTL_WIN_NEXT      2'h1
`define CMPCTL_WIN_NEXT2     2'h2
`define CMPCTL_COND_BOTH     2'h0
`define CMPCTL_COND_FALL     2'h2
`define CMPCTL_COND_RISE     2'h3
`define CMPCTL_COND_ABOVE    2'h0
`define CMPCTL_COND_INSIDE   2'h1
`define CMPCTL_COND_BELOW    2'h2
`define CMPCTL_COND_OUTSIDE  2'h3
`define CMPCTL_POS_ABOVE     2'h0
`define CMPCTL_POS_INSIDE    2'h1
`define CMPCTL_POS_BELOW     2'h2

`endif

// File: cmpctl_core_model.sv
// behavioural analog core; pin levels in steps of vref/256
// assumes enable and selects come from the control block on pclk
`timescale 1ns/1ps
`default_nettype none
module cmpctl_core_model #(parameter STARTUP = 6) (
  // control side
  input  wire logic        pclk,
  input  wire logic        core_enable,
  input  wire logic [2:0]  positive_input_select,
  input  wire logic [2:0]  negative_input_select,
  input  wire logic [7:0]  internal_threshold_level,
  // pin levels and results
  input  wire logic [31:0] plus_lvl,
  input  wire logic [23:0] minus_lvl,
  output logic             cmp_raw,
  output logic             core_ready
);
  int         cnt = 0;
  logic       tog = 0;
  logic [7:0] pos;
  logic [7:0] neg;
  // four plus pins; three minus pins or the threshold level
  always_comb
  begin
    pos = plus_lvl[positive_input_select[1:0]*8 +: 8];
    neg = negative_input_select == 3 ? internal_threshold_level
        : minus_lvl[negative_input_select[1:0]*8 +: 8];
  end
  // start-up count; a stopped core floats, shown as a toggling line
  always @(posedge pclk)
  begin
    cnt <= core_enable ? (cnt < STARTUP ? cnt + 1 : cnt) : 0;
    tog <= ~tog;
  end
  assign core_ready = core_enable && cnt == STARTUP;
  assign cmp_raw = core_ready ? pos > neg : tog;
endmodule // cmpctl_core_model
`default_nettype wire

// File: cmpctl_properties.sv
// assertions on the comparator control block ports
// assumes one clock pclk and async active-low presetn
`timescale 1ns/1ps
`default_nettype none
module cmpctl_properties #(parameter ADDR_WIDTH = 8) (
  // clock, reset and apb
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic                  pready,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  // core, pin, event and irq
  input wire logic                  cmp_raw,
  input wire logic                  core_ready,
  input wire logic                  core_enable,
  input wire logic                  sleep_powerdown,
  input wire logic                  out_pin_o,
  input wire logic                  out_pin_oe,
  input wire logic                  level_event,
  input wire logic                  irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  // three edges of a core still starting, with no register traffic
  sequence s_quiet; (!core_ready && !psel) [*3]; endsequence

  a_ready_once: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not a single cycle");
  a_bad_addr: assert property (psel && !penable && (paddr[1:0] != 0 ||
    paddr > 'h1c || paddr == 'h0c || paddr == 'h10) |=> pslverr)
    else $error("no error for unmapped address");
  a_err_read: assert property (pslverr |-> pready && (pwrite || prdata == 0))
    else $error("error answer malformed");
  a_pin_follow: assert property ($changed(cmp_raw) && core_enable &&
    core_ready && $past(core_ready) && !$past(penable) |=>
    $changed(out_pin_o))
    else $error("pin missed a result change");
  a_event_pin: assert property (out_pin_oe |->
    level_event == out_pin_o) else $error("event differs from pin");
  a_init_hold: assert property (s_quiet |=> $stable(out_pin_o))
    else $error("output moved before core ready");
  a_irq_held: assert property (irq && !(psel && pwrite) |=> irq)
    else $error("irq dropped without a clear");
  a_pd_off: assert property (sleep_powerdown |=>
    !core_enable && !out_pin_oe) else $error("power-down left core on");
endmodule // cmpctl_properties

bind cmpctl_top cmpctl_properties #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .cmp_raw(cmp_raw), .core_ready(core_ready),
  .core_enable(core_enable), .sleep_powerdown(sleep_powerdown),
  .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe),
  .level_event(level_event), .irq(irq));
`default_nettype wire

// File: cmpctl_top.v
// digital control logic around one analog comparator: apb registers,
// output path, window evaluation, flags, irq and level event.
// assumes the analog core, both partner comparators and the sleep
// controller are synchronous to pclk; the level event is registered,
// so it trails the core result by one clock.
//
// Operation
// RL1 - raw result high when positive input exceeds negative, else low
// RL2 - pin output is raw result xor inversion bit
// RL3 - during start-up output holds the initial level bit
// RL4 - pin driven only while pin output enable is one
// RL5 - software picks inputs and pin enable before enabling
// RL6 - positive select: four pins; negative: three pins or threshold
// RL7 - 8-bit threshold level; threshold is value/256 times reference
// RL8 - hysteresis select passed to the analog core
// RL9 - power profile forwarded to the analog core
// RL10 - partner select picks the paired comparator for window mode
// RL11 - software sets both paired positive selects to the same pin
// RL12 - window position reports above, inside or below
// RL13 - window condition: above, inside, below or outside
// RL14 - condition match reads one while position equals condition
// RL15 - normal mode condition: rising, falling or both edges
// RL16 - interrupt condition sets the flag regardless of enable
// RL17 - irq issued only while compare irq enable is one
// RL18 - irq stays active until software clears the flag
// RL19 - level event follows the comparator output
// RL20 - block consumes no event, only generates one
// RL21 - idle sleep changes nothing
// RL22 - standby disables comparator unless keep-running bit set
// RL23 - power-down disables comparator and pin drive
// RL24 - hysteresis codes none, small, medium, large as 0..3
// RL25 - power profiles 0..2, code 3 reserved
// RL26 - partner codes off, next, next-but-one; 3 reserved
// RL27 - threshold level resets to all ones
// RL28 - flag cleared by writing one, zero leaves it
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cmpctl_consts.vh"

module cmpctl_top
#(
  parameter ADDR_WIDTH = 8
)
(
  // clock and reset
  input  wire                  pclk,
  input  wire                  presetn,
  // apb slave
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [ADDR_WIDTH-1:0] paddr,
  input  wire [31:0]           pwdata,
  output reg                   pready,
  output reg  [31:0]           prdata,
  output reg                   pslverr,
  // analog core results
  input  wire                  cmp_raw,
  input  wire                  core_ready,
  input  wire                  partner_next_raw,
  input  wire                  partner_next2_raw,
  // analog core settings
  output reg                   core_enable,
  output reg  [2:0]            positive_input_select,
  output reg  [2:0]            negative_input_select,
  output reg  [1:0]            hysteresis_select,
  output reg  [1:0]            power_profile,
  output reg  [7:0]            internal_threshold_level,
  output reg  [1:0]            window_partner_select,
  // sleep state
  input  wire                  sleep_standby,
  input  wire                  sleep_powerdown,
  // pin
  output reg                   out_pin_o,
  output reg                   out_pin_oe,
  // event and irq
  output reg                   level_event,
  output reg                   irq
);

  // software-held control bits
  reg        enable;
  reg        pin_output_enable;
  reg        keep_running_in_standby;
  reg        invert;
  reg        output_initial_level;
  reg        compare_irq_enable;
  reg [1:0]  irq_condition_select;
  // status and edge history
  reg        irq_flag;
  reg [1:0]  window_position;
  reg        condition_match;
  reg        match_prev;
  reg        out_prev;

  // decode helpers
  wire [2:0] reg_idx = paddr[4:2];
  wire       aligned = (paddr[1:0] == 2'b00) &&
                       (paddr[ADDR_WIDTH-1:5] == {(ADDR_WIDTH-5){1'b0}});
  wire       wr_take = psel && penable && pready && pwrite;
  wire       win_on  = (window_partner_select == `CMPCTL_WIN_NEXT) ||
                       (window_partner_select == `CMPCTL_WIN_NEXT2);

  // comparator may run: idle leaves it alone, standby needs the
  // keep-running bit, power-down always stops it
  wire       run_ok  = enable && !sleep_powerdown &&
                       !(sleep_standby && !keep_running_in_standby);
  // [RL21] [RL22] [RL23]

  // output path; the initial level covers start-up so the pin and
  // the event never see the core's unsettled output
  wire       next_out = (core_enable && core_ready) ?
                        (cmp_raw ^ invert) :   // [RL1] [RL2]
                        output_initial_level;  // [RL3]

  // window coding: this instance holds the upper limit and the
  // partner the lower one; with both watching the same input pin,
  //   own high              -> above
  //   own low, partner high -> inside
  //   both low              -> below
  // a partner code of 3 is reserved and leaves the window off
  wire       partner_raw = (window_partner_select == `CMPCTL_WIN_NEXT2) ?
                           partner_next2_raw : partner_next_raw; // [RL10]
  reg  [1:0] next_pos;
  reg        next_match;
  reg        edge_hit;

  // window position and match
  always @*
  begin
    if (cmp_raw)
      next_pos = `CMPCTL_POS_ABOVE;           // [RL12]
    else if (partner_raw)
      next_pos = `CMPCTL_POS_INSIDE;          // [RL12]
    else
      next_pos = `CMPCTL_POS_BELOW;           // [RL12]
    case (irq_condition_select)               // [RL13]
      `CMPCTL_COND_ABOVE:  next_match = (next_pos == `CMPCTL_POS_ABOVE);
      `CMPCTL_COND_INSIDE: next_match = (next_pos == `CMPCTL_POS_INSIDE);
      `CMPCTL_COND_BELOW:  next_match = (next_pos == `CMPCTL_POS_BELOW);
      default:             next_match = (next_pos != `CMPCTL_POS_INSIDE);
    endcase
    if (!win_on || !core_enable || !core_ready)
      next_match = 1'b0;
  end

  // normal-mode edge select on the registered output; code 1 has no
  // meaning in normal mode and raises nothing
  always @*
  begin
    case (irq_condition_select)               // [RL15]
      `CMPCTL_COND_BOTH: edge_hit = next_out != out_prev;
      `CMPCTL_COND_FALL: edge_hit = !next_out && out_prev;
      `CMPCTL_COND_RISE: edge_hit = next_out && !out_prev;
      default:           edge_hit = 1'b0;
    endcase
  end

  // window mode raises on entering the selected state
  wire       cond_event = win_on ? (next_match && !match_prev) :
                          (core_enable && core_ready && edge_hit);
  wire       flag_clear = wr_take && aligned &&
                          (reg_idx == `CMPCTL_IDX_STATUS) &&
                          pwdata[`CMPCTL_ST_FLAG];

  // run permission reaches the core one edge late
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_enable <= 1'b0;
    else
      core_enable <= run_ok;                  // [RL21] [RL22] [RL23]
  end

  // window status; the position is held while the core is off or
  // still starting, so its floating output never reads as a move
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      window_position <= `CMPCTL_POS_ABOVE;
      condition_match <= 1'b0;
      match_prev      <= 1'b0;
    end
    else
    begin
      if (core_enable && core_ready)
        window_position <= next_pos;          // [RL12]
      condition_match <= next_match;          // [RL14]
      match_prev      <= next_match;
    end
  end

  // pin, event and edge history share one level, so the pin and the
  // event can never disagree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_prev    <= 1'b0;
      out_pin_o   <= 1'b0;
      level_event <= 1'b0;
    end
    else
    begin
      out_prev    <= next_out;
      out_pin_o   <= next_out;                // [RL2]
      level_event <= next_out;                // [RL19] [RL20]
    end
  end

  // pin drive needs the software enable and is cut in power-down
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_pin_oe <= 1'b0;
    else
      out_pin_oe <= pin_output_enable && !sleep_powerdown; // [RL4] [RL23]
  end

  // interrupt flag; a new condition wins over a clear in the same
  // cycle, so no event is lost to a late clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_flag <= 1'b0;
    else if (cond_event)
      irq_flag <= 1'b1;                       // [RL16]
    else if (flag_clear)
      irq_flag <= 1'b0;                       // [RL28]
  end

  // irq line follows the flag's next value, gated by the enable, so
  // flag and line change on the same edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= (cond_event || (irq_flag && !flag_clear)) &&
             compare_irq_enable;              // [RL17] [RL18]
  end

  // register map, one byte per aligned word, upper bits read zero:
  //   0x00 main: enable, hysteresis, power profile, pin enable,
  //        keep running in standby
  //   0x04 window partner select
  //   0x08 negative and positive select, initial level, inversion
  //   0x14 threshold level
  //   0x18 irq enable and condition select
  //   0x1c status: flag (write one to clear), match, position
  //   0x0c, 0x10, unaligned words and anything past 0x1c answer
  //   with an error and ignore writes
  // reserved field codes are stored as written; the core decides
  // what they mean, and partner code 3 keeps the window off
  // writes land at the access edge only, so an abandoned setup
  // cycle never disturbs a setting

  // register writes, taken at the access edge only
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable                   <= 1'b0;
      hysteresis_select        <= 2'h0;
      power_profile            <= 2'h0;
      pin_output_enable        <= 1'b0;
      keep_running_in_standby  <= 1'b0;
      window_partner_select    <= `CMPCTL_WIN_OFF;
      negative_input_select    <= 3'h0;
      positive_input_select    <= 3'h0;
      output_initial_level     <= 1'b0;
      invert                   <= 1'b0;
      compare_irq_enable       <= 1'b0;
      irq_condition_select     <= 2'h0;
    end
    else if (wr_take && aligned)
    begin
      if (reg_idx == `CMPCTL_IDX_MAIN)
      begin
        enable                  <= pwdata[`CMPCTL_MAIN_EN];
        hysteresis_select       <= pwdata[`CMPCTL_MAIN_HYS_LO +: 2]; // [RL8] [RL24]
        power_profile           <= pwdata[`CMPCTL_MAIN_PWR_LO +: 2]; // [RL9] [RL25]
        pin_output_enable       <= pwdata[`CMPCTL_MAIN_PINEN];
        keep_running_in_standby <= pwdata[`CMPCTL_MAIN_STDBY];
      end
      else if (reg_idx == `CMPCTL_IDX_WINDOW)
        window_partner_select <= pwdata[1:0]; // [RL26]
      else if (reg_idx == `CMPCTL_IDX_INSEL)
      begin
        // [RL6] codes above 3 are reserved; held as written
        negative_input_select <= pwdata[`CMPCTL_INSEL_NEG_LO +: 3];
        positive_input_select <= pwdata[`CMPCTL_INSEL_POS_LO +: 3];
        output_initial_level  <= pwdata[`CMPCTL_INSEL_INIT];
        invert                <= pwdata[`CMPCTL_INSEL_INV];
      end
      else if (reg_idx == `CMPCTL_IDX_IRQCTL)
      begin
        compare_irq_enable   <= pwdata[`CMPCTL_IRQ_EN];
        irq_condition_select <= pwdata[`CMPCTL_IRQ_COND_LO +: 2];
      end
    end
  end

  // threshold level keeps its own process: it is the one setting
  // that resets to all ones, the highest threshold
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      internal_threshold_level <= `CMPCTL_RST_THRESH; // [RL27]
    else if (wr_take && aligned && (reg_idx == `CMPCTL_IDX_THRESH))
      internal_threshold_level <= pwdata[7:0]; // [RL7]
  end

  // read mux; reserved bits read as zero; an unaligned word or a
  // hole in the map reads zero and raises the error, which the
  // apb answer registers together with ready
  reg  [7:0] rd_byte;
  reg        rd_err;
  always @*
  begin
    rd_byte = `CMPCTL_RST_ZERO;
    rd_err  = 1'b0;
    if (!aligned)
      rd_err = 1'b1;
    else if (reg_idx == `CMPCTL_IDX_MAIN)
      rd_byte = {keep_running_in_standby, pin_output_enable, 1'b0,
                 power_profile, hysteresis_select, enable};
    else if (reg_idx == `CMPCTL_IDX_WINDOW)
      rd_byte = {6'h00, window_partner_select};
    else if (reg_idx == `CMPCTL_IDX_INSEL)
      rd_byte = {invert, output_initial_level, positive_input_select,
                 negative_input_select};
    else if (reg_idx == `CMPCTL_IDX_THRESH)
      rd_byte = internal_threshold_level;
    else if (reg_idx == `CMPCTL_IDX_IRQCTL)
      rd_byte = {2'h0, irq_condition_select, 3'h0, compare_irq_enable};
    else if (reg_idx == `CMPCTL_IDX_STATUS)
      rd_byte = {window_position, 1'b0, condition_match, 3'h0,
                 irq_flag};                   // [RL12] [RL14]
    else
      rd_err = 1'b1;
  end

  // apb handshake: no wait state, yet read data comes from a flop;
  // ready stands for exactly one access cycle per setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  // error answer for unaligned or unmapped words, with ready
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel && !penable && rd_err;
  end

  // read data is captured at setup and then held, so a slow master
  // still sees it after ready has gone; writes read back as zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= pwrite ? 32'h0000_0000 : {24'h000000, rd_byte};
  end

endmodule // cmpctl_top

`default_nettype wire

// File: tb_top.sv
// self-checking bench for the comparator control block
// assumes the core model and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pn = 0, pn2 = 0, sb = 0, pd = 0, e, oo, oe, ev, irq;
  logic        pready, pslverr, cmp_raw, core_ready, core_enable;
  logic [7:0]  paddr = 0, th;
  logic [31:0] pwdata = 0, prdata, r, plus = 0;
  logic [2:0]  ps, ns;
  logic [1:0]  hs, pw, ws;
  int          errors = 0, cmp_count = 0, c, i, p, flag;
  int          adr[6] = '{0, 4, 8, 'h14, 'h18, 'h1c};
  int          bad[4] = '{'h0c, 'h10, 'h20, 'h02};
  int          cond[3] = '{0, 2, 3};

  always #2.5 pclk = ~pclk;

  cmpctl_top u_cmpctl_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .cmp_raw(cmp_raw),
    .core_ready(core_ready), .partner_next_raw(pn), .partner_next2_raw(pn2),
    .core_enable(core_enable), .positive_input_select(ps),
    .negative_input_select(ns), .hysteresis_select(hs), .power_profile(pw),
    .internal_threshold_level(th), .window_partner_select(ws),
    .sleep_standby(sb), .sleep_powerdown(pd), .out_pin_o(oo),
    .out_pin_oe(oe), .level_event(ev), .irq(irq));
  cmpctl_core_model u_cmpctl_core_model (.pclk(pclk),
    .core_enable(core_enable), .positive_input_select(ps),
    .negative_input_select(ns), .internal_threshold_level(th),
    .plus_lvl(plus), .minus_lvl(24'h0), .cmp_raw(cmp_raw),
    .core_ready(core_ready));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // no cycle count is assumed; only the watchdog ends a stuck wait
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wait_ready;
    for (int n = 0; n < 20 && core_ready !== 1; n++) @(posedge pclk);
    chk(core_ready, 1);
  endtask
  task end_of_test;
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // main sequence: registers, normal mode, window mode, sleep
  initial
  begin
    void'($urandom(4833));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    foreach (adr[k])
    begin
      apb(0, adr[k], 0);
      chk(r, k == 3 ? 'hff : 0);
    end
    for (i = 0; i < 4; i++)
    begin
      p = $urandom;
      apb(1, 0, i << 1 | i << 3);
      apb(1, 4, i);
      apb(1, 8, p[5:0]);
      apb(1, 'h14, p[15:8]);
      apb(0, 0, 0);
      chk(r, i << 1 | i << 3);
      chk(hs, i);
      chk(pw, i);
      chk(ws, i);
      chk({ps, ns}, p[5:0]);
      chk(th, p[15:8]);
    end
    foreach (bad[k])
    begin
      apb(0, bad[k], 0);
      chk(r, 0);
      chk(e, 1);
    end
    apb(1, 4, 0);
    apb(1, 'h14, 'h80);
    apb(1, 8, 'h1b); // inputs chosen before the enable write
    apb(1, 0, 'h41);
    wait_ready();
    foreach (cond[k])
    begin
      c = $urandom_range(1);
      apb(1, 'h18, cond[k] << 4 | c);
      apb(1, 'h1c, 1);
      flag = 0;
      for (i = 0; i < 4; i++)
      begin
        @(posedge pclk);
        plus[31:24] <= i[0] ? 'h40 : 'hc0;
        repeat (3) @(posedge pclk);
        flag |= cond[k] == 0 || cond[k] == 3 ^ i[0] && cond[k] != 0;
        chk({oo, ev, oe}, {!i[0], !i[0], 1'b1});
        apb(0, 'h1c, 0);
        chk({r[0], irq}, {flag[0], flag[0] & c[0]});
      end
      apb(1, 'h1c, 0);
      apb(1, 'h3c, 1);
      apb(0, 'h1c, 0);
      chk(r[0], flag);
      apb(1, 'h1c, 1);
      apb(0, 'h1c, 0);
      chk({r[0], irq}, 0);
    end
    apb(1, 8, 'h9b);
    apb(0, 8, 0);
    chk(oo, 1);
    apb(1, 0, 'h40);
    apb(1, 8, 'h5b);
    apb(1, 0, 'h41);
    repeat (3) @(posedge pclk);
    chk(oo, 1);
    wait_ready();
    for (c = 0; c < 4; c++)
    begin
      apb(1, 4, 1 + c[0]);
      apb(1, 'h18, c << 4);
      for (i = 0; i < 3; i++)
      begin
        @(posedge pclk);
        plus[31:24] <= i == 0 ? 'hc0 : 'h40;
        pn <= c[0] ? i == 2 : i != 2; // partner sees the same pin
        pn2 <= c[0] ? i != 2 : i == 2;
        apb(0, 'h1c, 0);
        chk(r[7:6], i);
        chk(r[4], c == 3 ? i != 1 : c == i);
      end
    end
    pd <= 1;
    repeat (3) @(posedge pclk);
    chk({core_enable, oe}, 0);
    pd <= 0;
    sb <= 1;
    repeat (3) @(posedge pclk);
    chk(core_enable, 0);
    apb(1, 0, 'hc1);
    repeat (3) @(posedge pclk);
    chk(core_enable, 1);
    end_of_test;
  end

  // watchdog well beyond the expected run length
  initial
  begin
    #100000;
    errors++;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
